/* File: core/pa_pkg.sv */
// Shared constants and types for the port A pin control block
`default_nettype none

package pa_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int PA_W = 8;
   localparam int PA_AW = 3;
   localparam int PA_CTL_W = 7;
   localparam int PA_OSC_W = 2;
   localparam int PA_DIV_W = 2;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [PA_AW-1:0] ADR_PORT = 3'h0;
   localparam logic [PA_AW-1:0] ADR_LAT = 3'h1;
   localparam logic [PA_AW-1:0] ADR_DIR = 3'h2;
   localparam logic [PA_AW-1:0] ADR_ANS = 3'h3;
   localparam logic [PA_AW-1:0] ADR_CTL = 3'h4;
   localparam logic [PA_AW-1:0] ADR_OSC = 3'h5;

   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [PA_W-1:0] LAT_RST = 8'h00;
   localparam logic [PA_W-1:0] DIR_RST = 8'hFF;
   localparam logic [PA_W-1:0] ANS_RST = 8'h2F;
   localparam logic [PA_W-1:0] ANS_MASK = 8'h2F;
   localparam logic [PA_W-1:0] DAC_PIN_MASK = 8'h04;
   localparam logic [PA_CTL_W-1:0] CTL_RST = 7'h00;
   localparam logic [PA_DIV_W-1:0] DIV_RST = 2'h0;

   // ----------------------------------------------------------------
   // Control register bit positions
   // ----------------------------------------------------------------
   localparam int CTL_DAC = 0;
   localparam int CTL_UNIT5 = 1;
   localparam int CTL_SRT = 2;
   localparam int CTL_C1 = 3;
   localparam int CTL_C2 = 4;
   localparam int CTL_SRI = 5;
   localparam int CTL_ICLK = 6;

   // ----------------------------------------------------------------
   // Pin positions
   // ----------------------------------------------------------------
   localparam int PIN_DAC = 2;
   localparam int PIN_CCP = 4;
   localparam int PIN_SS = 5;
   localparam int PIN_ICLK = 6;
   localparam int PIN_OSCI = 7;

   // ----------------------------------------------------------------
   // Oscillator mode field codes and decoded modes
   // ----------------------------------------------------------------
   localparam logic [PA_OSC_W-1:0] OSC_INT = 2'h0;
   localparam logic [PA_OSC_W-1:0] OSC_EXT = 2'h1;
   localparam logic [PA_OSC_W-1:0] OSC_RC = 2'h2;
   localparam logic [PA_OSC_W-1:0] OSC_RST = 2'h0;

   typedef enum logic [2:0] {
      PA_OSC_INT = 3'b001,
      PA_OSC_EXT = 3'b010,
      PA_OSC_RC = 3'b100
   } pa_osc_t;

endpackage

`default_nettype wire

/* File: core/pa_quarter_div.sv */
// Quarter-rate clock divider for the instruction clock output
`default_nettype none

module pa_quarter_div (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   output logic qclk_out
);
   import pa_pkg::*;

   typedef struct packed {
      logic [PA_DIV_W-1:0] cnt;
   } pa_div_t;

   pa_div_t s_reg;
   pa_div_t s_next;

   // Free-running count, top bit is one quarter of the input rate
   always_comb begin
      s_next = s_reg;
      s_next.cnt = s_reg.cnt + 2'h1;
   end

   // State register
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         s_reg.cnt <= DIV_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign qclk_out = s_reg.cnt[PA_DIV_W-1];

endmodule

`default_nettype wire

/* File: core/pa_port_ctrl.sv */
// Port A pin control: direction, analog select, latch and output overrides
//
// Contract
// - Direction 0 drives pin from latch; analog select leaves that drive unchanged.
// - Direction 1 reads pin level; analog select disables the digital input.
// - DAC output on pin 2 kills latch drive and digital input.
// - Pin 4 is a digital input after reset, no analog select.
// - Enabled compare/PWM unit 5 drives pin 4 instead of latch.
// - SR latch true output on pin 4 beats unit 5 and latch.
// - Pin 5 digital level feeds SPI slave select when input and digital.
// - Pin 6 is digital only in internal modes without clock output.
// - RC mode puts quarter-rate instruction clock on pin 6.
// - External oscillator modes disable pin 7 output and input.
// - Reading the latch register returns latched value, not pin level.
//
// Added by the designer: the register offsets and the address-and-strobe port.
`default_nettype none

module pa_port_ctrl (
   input wire logic clock_in,
   input wire logic sys_rst_in,
   // Register port
   input wire logic [pa_pkg::PA_AW-1:0] addr_in,
   input wire logic [pa_pkg::PA_W-1:0] wr_data_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [pa_pkg::PA_W-1:0] rd_data_out,
   // Pins
   input wire logic [pa_pkg::PA_W-1:0] pin_in,
   output logic [pa_pkg::PA_W-1:0] pin_out,
   output logic [pa_pkg::PA_W-1:0] pin_oe_out,
   // On-chip peripheral outputs
   input wire logic capture_compare_unit_5_in,
   input wire logic sr_latch_true_out_in,
   input wire logic sr_latch_inverted_out_in,
   input wire logic comparator_one_out_in,
   input wire logic comparator_two_out_in,
   // Peripheral inputs taken from the pins
   output logic spi_slave_select_one_out,
   output logic timer_zero_ext_clock_out,
   output logic capture_compare_unit_5_out
);
   import pa_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PA_W-1:0] lat;
      logic [PA_W-1:0] dir;
      logic [PA_W-1:0] ans;
      logic [PA_CTL_W-1:0] ctl;
      logic [PA_OSC_W-1:0] osc;
      logic [PA_W-1:0] pout;
      logic [PA_W-1:0] poe;
      logic [PA_W-1:0] rdat;
      logic ss;
      logic t0;
      logic cap;
   } pa_state_t;

   pa_state_t s_reg;
   pa_state_t s_next;

   pa_osc_t osc_mode;
   logic qclk;
   logic osc_int;
   logic iclk_en;
   logic [PA_W-1:0] ans_eff;
   logic [PA_W-1:0] dac_mask;
   logic [PA_W-1:0] osc_mask;
   logic [PA_W-1:0] in_en;
   logic [PA_W-1:0] out_en;
   logic [PA_W-1:0] base_oe;
   logic [PA_W-1:0] din;

   // ----------------------------------------------------------------
   // Quarter-rate clock source
   // ----------------------------------------------------------------
   pa_quarter_div u_div (
      .clock_in(clock_in),
      .sys_rst_in(sys_rst_in),
      .qclk_out(qclk)
   );

   // ----------------------------------------------------------------
   // Mode decode and per-pin enables
   // ----------------------------------------------------------------

   // Oscillator field to one-hot mode, spare code acts as external
   assign osc_mode = (s_reg.osc == OSC_INT) ? PA_OSC_INT :
                     (s_reg.osc == OSC_RC) ? PA_OSC_RC : PA_OSC_EXT;
   assign osc_int = (osc_mode == PA_OSC_INT);
   assign iclk_en = s_reg.ctl[CTL_ICLK];

   // Analog select only where the pin has one
   assign ans_eff = s_reg.ans & ANS_MASK;

   // DAC output removes pin 2 from the digital paths
   assign dac_mask = s_reg.ctl[CTL_DAC] ? DAC_PIN_MASK : 8'h00;

   // Oscillator pins are digital only in internal mode
   assign osc_mask = {osc_int, osc_int & ~iclk_en, 6'h3F};

   // Digital input and latch output enables
   assign in_en = ~ans_eff & ~dac_mask & osc_mask;
   assign out_en = ~dac_mask & osc_mask;

   // Per-pin latch drive and gated digital input
   genvar gi;
   generate
      for (gi = 0; gi < PA_W; gi++) begin : g_pin
         // Analog select does not enter the output enable
         assign base_oe[gi] = ~s_reg.dir[gi] & out_en[gi];
         assign din[gi] = pin_in[gi] & in_en[gi];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.rdat = 8'h00;

      // Register writes; port value writes land in the latch
      if (wr_in) begin
         case (addr_in)
            ADR_PORT, ADR_LAT: begin
               s_next.lat = wr_data_in;
            end
            ADR_DIR: begin
               s_next.dir = wr_data_in;
            end
            ADR_ANS: begin
               s_next.ans = wr_data_in & ANS_MASK;
            end
            ADR_CTL: begin
               s_next.ctl = wr_data_in[PA_CTL_W-1:0];
            end
            ADR_OSC: begin
               s_next.osc = wr_data_in[PA_OSC_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // Register reads, data one cycle later, unmapped reads zero
      if (rd_in) begin
         case (addr_in)
            ADR_PORT: begin
               s_next.rdat = din;
            end
            ADR_LAT: begin
               s_next.rdat = s_reg.lat;
            end
            ADR_DIR: begin
               s_next.rdat = s_reg.dir;
            end
            ADR_ANS: begin
               s_next.rdat = ans_eff;
            end
            ADR_CTL: begin
               s_next.rdat = {1'b0, s_reg.ctl};
            end
            ADR_OSC: begin
               s_next.rdat = {6'h00, s_reg.osc};
            end
            default: begin
               s_next.rdat = 8'h00;
            end
         endcase
      end

      // Default pin drive from the latch
      s_next.pout = s_reg.lat;
      s_next.poe = base_oe;

      // Pin 4 overrides: SR latch, then unit 5, then comparator one
      if (!s_reg.dir[PIN_CCP]) begin
         if (s_reg.ctl[CTL_SRT]) begin
            s_next.pout[PIN_CCP] = sr_latch_true_out_in;
         end else if (s_reg.ctl[CTL_UNIT5]) begin
            s_next.pout[PIN_CCP] = capture_compare_unit_5_in;
         end else if (s_reg.ctl[CTL_C1]) begin
            s_next.pout[PIN_CCP] = comparator_one_out_in;
         end
      end

      // Pin 5 overrides: SR latch inverted, then comparator two
      if (!s_reg.dir[PIN_SS]) begin
         if (s_reg.ctl[CTL_SRI]) begin
            s_next.pout[PIN_SS] = sr_latch_inverted_out_in;
         end else if (s_reg.ctl[CTL_C2]) begin
            s_next.pout[PIN_SS] = comparator_two_out_in;
         end
      end

      // Pin 6 clock output regardless of direction
      case (osc_mode)
         PA_OSC_INT, PA_OSC_RC: begin
            if (iclk_en) begin
               s_next.poe[PIN_ICLK] = 1'b1;
               s_next.pout[PIN_ICLK] = qclk;
            end
         end
         PA_OSC_EXT: begin
            s_next.poe[PIN_ICLK] = 1'b0;
         end
         default: begin
            s_next.poe[PIN_ICLK] = 1'b0;
         end
      endcase

      // SPI slave select from pin 5, idle high otherwise
      if (s_reg.dir[PIN_SS] && !ans_eff[PIN_SS]) begin
         s_next.ss = pin_in[PIN_SS];
      end else begin
         s_next.ss = 1'b1;
      end

      // Timer and capture inputs from pin 4
      s_next.t0 = din[PIN_CCP];
      s_next.cap = din[PIN_CCP];
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         s_reg.lat <= LAT_RST;
         s_reg.dir <= DIR_RST;
         s_reg.ans <= ANS_RST;
         s_reg.ctl <= CTL_RST;
         s_reg.osc <= OSC_RST;
         s_reg.pout <= 8'h00;
         s_reg.poe <= 8'h00;
         s_reg.rdat <= 8'h00;
         s_reg.ss <= 1'b1;
         s_reg.t0 <= 1'b0;
         s_reg.cap <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rd_data_out = s_reg.rdat;
   assign pin_out = s_reg.pout;
   assign pin_oe_out = s_reg.poe;
   assign spi_slave_select_one_out = s_reg.ss;
   assign timer_zero_ext_clock_out = s_reg.t0;
   assign capture_compare_unit_5_out = s_reg.cap;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence rd_port_s;
      rd_in && (addr_in == ADR_PORT);
   endsequence

   sequence lat_wr_s;
      wr_in && (addr_in == ADR_LAT);
   endsequence

   sequence lat_rd_s;
      rd_in && (addr_in == ADR_LAT);
   endsequence

   sequence rc_clk_s;
      ((s_reg.osc == OSC_RC) && s_reg.ctl[CTL_ICLK])[*6];
   endsequence

   property rmw_p;
      lat_wr_s ##1 lat_rd_s |=> rd_data_out == $past(wr_data_in, 2);
   endproperty

   property quarter_p;
      rc_clk_s |-> pin_oe_out[PIN_ICLK] &&
         (pin_out[PIN_ICLK] != $past(pin_out[PIN_ICLK], 2)) &&
         (pin_out[PIN_ICLK] == $past(pin_out[PIN_ICLK], 4));
   endproperty

   latch_drive_a: assert property (
      !s_reg.dir[0] |=> pin_oe_out[0] && (pin_out[0] == $past(s_reg.lat[0])))
      else $error("pin 0 not driven from latch");

   analog_keep_a: assert property (
      (!s_reg.dir[1] && s_reg.ans[1]) |=> pin_oe_out[1] && (pin_out[1] == $past(s_reg.lat[1])))
      else $error("analog select changed pin 1 drive");

   port_read_a: assert property (
      (rd_port_s and (s_reg.dir[0] && !s_reg.ans[0])) |=> rd_data_out[0] == $past(pin_in[0]))
      else $error("port read lost pin 0 level");

   analog_in_off_a: assert property (
      (rd_port_s and s_reg.ans[3]) |=> !rd_data_out[3])
      else $error("pin 3 digital input not disabled");

   dac_pin_off_a: assert property (
      s_reg.ctl[CTL_DAC] |=> !pin_oe_out[PIN_DAC])
      else $error("pin 2 driven with DAC output");

   dac_in_off_a: assert property (
      (rd_port_s and s_reg.ctl[CTL_DAC]) |=> !rd_data_out[PIN_DAC])
      else $error("pin 2 digital input active with DAC output");

   pin4_reset_a: assert property (
      $past(sys_rst_in) |-> s_reg.dir[PIN_CCP] && !pin_oe_out[PIN_CCP] && !s_reg.ans[PIN_CCP])
      else $error("pin 4 not digital input after reset");

   ccp_drive_a: assert property (
      (!s_reg.dir[PIN_CCP] && s_reg.ctl[CTL_UNIT5] && !s_reg.ctl[CTL_SRT])
      |=> pin_out[PIN_CCP] == $past(capture_compare_unit_5_in))
      else $error("pin 4 not driven by unit 5");

   srt_prio_a: assert property (
      (!s_reg.dir[PIN_CCP] && s_reg.ctl[CTL_SRT]) |=> pin_out[PIN_CCP] == $past(sr_latch_true_out_in))
      else $error("SR latch output lost priority on pin 4");

   ss_route_a: assert property (
      (s_reg.dir[PIN_SS] && !s_reg.ans[PIN_SS]) |=> spi_slave_select_one_out == $past(pin_in[PIN_SS]))
      else $error("slave select not taken from pin 5");

   iclk_pin_a: assert property (
      (osc_int && iclk_en) |=> pin_oe_out[PIN_ICLK] && !$past(in_en[PIN_ICLK]))
      else $error("pin 6 digital while clock output enabled");

   quarter_clk_a: assert property (quarter_p)
      else $error("pin 6 clock not at quarter rate");

   ext_osc_a: assert property (
      (s_reg.osc == OSC_EXT) |=> !pin_oe_out[PIN_OSCI] && !pin_oe_out[PIN_ICLK])
      else $error("pin 7 driven in external oscillator mode");

   ext_in_off_a: assert property (
      (rd_port_s and (s_reg.osc == OSC_EXT)) |=> !rd_data_out[PIN_OSCI])
      else $error("pin 7 digital input in external oscillator mode");

   latch_rmw_a: assert property (rmw_p)
      else $error("latch read did not return latched value");

   ans_mask_a: assert property (
      (rd_in && (addr_in == ADR_ANS)) |=> (rd_data_out & ~ANS_MASK) == 8'h00)
      else $error("analog select present on wrong pin");

endmodule

`default_nettype wire

/* File: bench/pa_board_model.sv */
// Board circuitry model that closes the loop on the port pins
`default_nettype none

module pa_board_model (
   input wire logic [pa_pkg::PA_W-1:0] pin_out_in,
   input wire logic [pa_pkg::PA_W-1:0] pin_oe_in,
   input wire logic [pa_pkg::PA_W-1:0] ext_lvl_in,
   output logic [pa_pkg::PA_W-1:0] pin_level_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import pa_pkg::*;

   // Driven pins show the block's level, released pins the board source level
   assign pin_level_out = (pin_out_in & pin_oe_in) | (ext_lvl_in & ~pin_oe_in);
endmodule

`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking testbench for the port A pin control block
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pa_pkg::*;

   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic clock_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [PA_AW-1:0] addr_in = '0;
   logic [PA_W-1:0] wr_data_in = '0;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [PA_W-1:0] ext_lvl = 8'h00;
   logic [4:0] per_in = 5'h00; // Unit5, SR true, SR inverted, comp1, comp2
   logic [PA_W-1:0] rd_data_out, pin_in, pin_out, pin_oe_out;
   logic ss_out, t0_out, cap_out;
   int bad_count = 0;
   int checked = 0;
   int lat, dir, ans, ctl, osc, highs;
   logic [7:0] e_oe, e_out, e_lvl, e_rd, dig;
   logic e_ss;

   // Clock at 100 ns period
   initial begin
      forever #50 clock_in = ~clock_in;
   end

   pa_port_ctrl uut (
      .clock_in(clock_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
      .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
      .capture_compare_unit_5_in(per_in[0]), .sr_latch_true_out_in(per_in[1]),
      .sr_latch_inverted_out_in(per_in[2]), .comparator_one_out_in(per_in[3]),
      .comparator_two_out_in(per_in[4]), .spi_slave_select_one_out(ss_out),
      .timer_zero_ext_clock_out(t0_out), .capture_compare_unit_5_out(cap_out)
   );

   pa_board_model board (
      .pin_out_in(pin_out), .pin_oe_in(pin_oe_out), .ext_lvl_in(ext_lvl),
      .pin_level_out(pin_in)
   );

   // ----------------------------------------------------------------
   // Compare, bus and verdict tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [PA_AW-1:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [PA_AW-1:0] a, input logic [7:0] exp);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      @(negedge clock_in);
      chk(rd_data_out, exp);
   endtask

   // Write, then read the latch back with no gap between the strobes
   task automatic wr_rd(input logic [PA_AW-1:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wr_data_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
      addr_in <= ADR_LAT;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      @(negedge clock_in);
      chk(rd_data_out, d); // Latch holds written value
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Reference model of pin drive, priority and input gating
   // ----------------------------------------------------------------
   task automatic model();
      e_oe = 8'(~dir);
      if (ctl[0]) e_oe[2] = 1'b0;
      if (osc != 0) e_oe[7:6] = 2'b00;
      e_out = 8'(lat);
      if (ctl[3]) e_out[4] = per_in[3];
      if (ctl[1]) e_out[4] = per_in[0];
      if (ctl[2]) e_out[4] = per_in[1];
      if (ctl[4]) e_out[5] = per_in[4];
      if (ctl[5]) e_out[5] = per_in[2];
      e_out = e_out & e_oe;
      e_lvl = e_out | (ext_lvl & ~e_oe);
      dig = 8'(~(ans & 'h2F));
      if (ctl[0]) dig[2] = 1'b0;
      if (osc != 0) dig[7:6] = 2'b00;
      e_rd = e_lvl & dig;
      e_ss = (dir[5] && !ans[5]) ? e_lvl[5] : 1'b1;
   endtask

   // Settle, then compare every output and read back all registers
   task automatic check_all();
      repeat (4) @(posedge clock_in);
      @(negedge clock_in);
      model();
      chk(pin_oe_out, e_oe); // Drive enables
      chk(pin_out & pin_oe_out, e_out); // Drive levels
      chk(8'(ss_out), 8'(e_ss)); // Slave select routing
      chk(8'(t0_out), 8'(e_lvl[4])); // Pin 4 digital level
      chk(8'(cap_out), 8'(e_lvl[4])); // Pin 4 capture level
      rd(ADR_PORT, e_rd); // Gated pin read
      rd(ADR_LAT, 8'(lat)); // Latch readback
      rd(ADR_DIR, 8'(dir)); // Direction readback
      rd(ADR_ANS, 8'(ans & 'h2F)); // Analog select bits
      rd(ADR_CTL, 8'(ctl)); // Override enables readback
      rd(ADR_OSC, 8'(osc)); // Oscillator mode readback
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'hc24b7789));
      repeat (8) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      ext_lvl <= 8'($urandom());
      // Defaults after reset
      lat = LAT_RST;
      dir = DIR_RST;
      ans = ANS_RST;
      ctl = CTL_RST;
      osc = OSC_RST;
      check_all();
      wr(3'h7, 8'hFF);
      rd(3'h6, 8'h00); // Unmapped index reads zero
      rd(3'h7, 8'h00); // Unmapped write ignored
      // Random configurations, all oscillator codes and overrides
      for (int i = 0; i < 150; i++) begin
         lat = $urandom() & 'hFF;
         dir = $urandom() & 'hFF;
         ans = $urandom() & 'hFF;
         ctl = $urandom() & 'h3F;
         osc = i % 4;
         @(posedge clock_in);
         ext_lvl <= 8'($urandom());
         per_in <= 5'($urandom());
         wr_rd(i[0] ? ADR_PORT : ADR_LAT, 8'(lat)); // Back-to-back latch
         wr(ADR_DIR, 8'(dir));
         wr(ADR_ANS, 8'(ans));
         wr(ADR_CTL, 8'(ctl));
         wr(ADR_OSC, 8'(osc));
         check_all();
      end
      // Instruction clock out on pin 6 per oscillator mode
      for (int m = 0; m < 3; m++) begin
         wr(ADR_OSC, 8'(m));
         wr(ADR_CTL, 8'h40);
         repeat (4) @(posedge clock_in);
         highs = 0;
         for (int k = 0; k < 8; k++) begin
            @(negedge clock_in);
            highs += pin_out[6];
         end
         chk(8'(pin_oe_out[6]), 8'(m != 1)); // Clock pin drive
         if (m != 1) chk(8'(highs), 8'd4); // Quarter-rate duty
      end
      wrap_up();
   end

   // Watchdog against a hung sequence
   initial begin
      #5000000;
      bad_count++;
      wrap_up();
   end
endmodule

`default_nettype wire
